// ===== tdcu_pkg.sv
package tdcu_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_CORE_STATUS  = 8'h07;
    localparam logic [7:0] IDX_COUNT_LO     = 8'h12;
    localparam logic [7:0] IDX_COUNT_HI     = 8'h13;
    localparam logic [7:0] IDX_CAP2_LO      = 8'h14;
    localparam logic [7:0] IDX_CAP2_HI      = 8'h15;
    localparam logic [7:0] IDX_PER_CAP_LO   = 8'h16;
    localparam logic [7:0] IDX_PER_CAP_HI   = 8'h17;
    // Shared printed offsets are split into separate words
    localparam logic [7:0] IDX_FLAGS        = 8'h20;
    localparam logic [7:0] IDX_ENABLES      = 8'h21;
    localparam logic [7:0] IDX_CTRL_ONE     = 8'h22;
    localparam logic [7:0] IDX_CTRL_TWO     = 8'h23;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_CLK_SEL   = 2;   // control one
    localparam int BIT_ED1_LO    = 4;
    localparam int BIT_ED2_LO    = 6;
    localparam int BIT_RUN       = 2;   // control two
    localparam int BIT_DUAL      = 3;
    localparam int BIT_OVF1      = 6;
    localparam int BIT_OVF2      = 7;
    localparam int BIT_CAP1_IRQ  = 2;   // flags and enables
    localparam int BIT_CAP2_IRQ  = 3;
    localparam int BIT_TMR_IRQ   = 6;
    localparam int BIT_PEIF      = 7;   // core status
    localparam int BIT_PEIE      = 3;

    // ----------------------------------------------------------------
    // Reset values and constants
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_CTRL     = 8'h00;
    localparam logic [7:0]  RST_FLAGS    = 8'h02;
    localparam logic [7:0]  RST_ENABLES  = 8'h00;
    localparam logic [7:0]  RST_CORE     = 8'h00;
    localparam logic [7:0]  FLAG_HW_MASK = 8'h4C;
    localparam logic [15:0] CNT_ZERO     = 16'h0000;
    localparam logic [15:0] CNT_MAX      = 16'hFFFF;
    localparam logic [3:0]  PRE_ZERO     = 4'h0;
    localparam logic [3:0]  PRE_FOURTH   = 4'h3;
    localparam logic [3:0]  PRE_SIXTEEN  = 4'hF;

    // Edge-select encodings
    localparam logic [1:0] EDGE_FALL  = 2'b00;
    localparam logic [1:0] EDGE_RISE  = 2'b01;
    localparam logic [1:0] EDGE_RISE4 = 2'b10;
    localparam logic [1:0] EDGE_RISE16 = 2'b11;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } tdcu_apb_req_s;

    typedef struct packed {
        logic [15:0] value;
        logic [3:0]  prescale;
        logic        pinPrev;
        logic        held;      // unread word present
        logic        readLo;
        logic        readHi;
        logic        master;    // hidden overflow
    } tdcu_chan_s;

endpackage : tdcu_pkg

// ===== tdcu_timer3.sv
`timescale 1ns/10ps
// Behaviour
// - Counter is 16 bits, read and written as low and high bytes.
// - Clock select 0 counts each cycle, 1 counts external pin falling edges.
// - Counter and its flag stay still while the run bit is clear.
// - Mode bit picks period plus one capture, or two captures.
// - Capture events: rising, falling, every 4th or every 16th rising edge.
// - A qualifying pin event copies the counter into that channel's capture.
// - A completed capture sets that channel's flag.
// - Period register becomes the first capture register when software asks.
// - In dual capture mode the counter wraps FFFFh to 0000h freely.
// - In dual capture mode each wrap sets the timer flag; software clears it.
// - In dual mode period bytes capture first pin using first edge field.
// - First capture sets its flag; the first capture enable passes it into the summary bit.
// - Event while a word is unread sets master overflow, keeps the word.
// - Reading both bytes moves master overflow to visible bit and clears it.
// - First channel behaves like the second only in dual mode; in period mode it never captures.
// - Both control registers reset to zero: timer stopped, internal clock.
module tdcu_timer3 (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // APB slave
    input  wire tdcu_pkg::tdcu_apb_req_s apbReq,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    // Pins
    input  wire logic                   firstCapturePin,
    input  wire logic                   secondCapturePin,
    input  wire logic                   thirdTimerExtClockPin,
    // Interrupt
    output logic                        irq
);
    import tdcu_pkg::*;

    typedef struct packed {
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic        extPrev;
        logic [15:0] count;
        logic [15:0] period;
        tdcu_chan_s  ch1;
        tdcu_chan_s  ch2;
        logic [7:0]  ctrlOne;
        logic [7:0]  ctrlTwo;
        logic [7:0]  flags;
        logic [7:0]  enables;
        logic [7:0]  core;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        irq;
    } tdcu_state_s;

    tdcu_state_s state_q;
    tdcu_state_s state_d;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Qualifies one pin edge against its edge-select field
    function automatic logic edgeHit(input logic [1:0] sel, input logic prev, input logic cur,
                                     input logic [3:0] pre);
        logic rise;
        rise = cur & ~prev;
        edgeHit = 1'b0;
        case (sel)
            EDGE_FALL:   edgeHit = prev & ~cur;
            EDGE_RISE:   edgeHit = rise;
            EDGE_RISE4:  edgeHit = rise && (pre[1:0] == PRE_FOURTH[1:0]);
            default:     edgeHit = rise && (pre == PRE_SIXTEEN);
        endcase
    endfunction : edgeHit

    // Advances one capture channel; captures, overflow, read tracking
    function automatic tdcu_chan_s chanStep(input tdcu_chan_s c, input logic [1:0] sel,
                                            input logic pin, input logic [15:0] cnt,
                                            input logic rdLo, input logic rdHi,
                                            output logic captured, output logic ovfLoad,
                                            output logic ovfVal);
        tdcu_chan_s n;
        logic hit;
        n = c;
        captured = 1'b0;
        ovfLoad = 1'b0;
        ovfVal = 1'b0;
        hit = edgeHit(sel, c.pinPrev, pin, c.prescale);
        n.pinPrev = pin;
        if (pin & ~c.pinPrev) begin
            n.prescale = c.prescale + 4'h1;
        end
        if (rdLo) begin
            n.readLo = 1'b1;
        end
        if (rdHi) begin
            n.readHi = 1'b1;
        end
        if (n.readLo && n.readHi) begin
            ovfLoad = 1'b1;
            ovfVal = c.master;
            n.master = 1'b0;
            n.held = 1'b0;
            n.readLo = 1'b0;
            n.readHi = 1'b0;
        end
        if (hit) begin
            if (c.held && n.held) begin
                n.master = 1'b1;
            end else begin
                n.value = cnt;
                n.held = 1'b1;
                n.readLo = 1'b0;
                n.readHi = 1'b0;
                captured = 1'b1;
            end
        end
        chanStep = n;
    endfunction : chanStep

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    logic        rd;
    logic        wr;
    logic [7:0]  idx;
    logic [7:0]  wByte;
    logic        tick;
    logic        dual;
    logic        wrapEvt;
    logic        cap1;
    logic        cap2;
    logic        ovl1;
    logic        ovl2;
    logic        ov1;
    logic        ov2;
    logic [7:0]  rByte;
    logic [7:0]  hwSet;

    always_comb begin
        state_d = state_q;
        idx = apbReq.paddr[9:2];
        wByte = apbReq.pwdata[7:0];
        rd = apbReq.psel && apbReq.penable && !apbReq.pwrite && !state_q.pready;
        wr = apbReq.psel && apbReq.penable && apbReq.pwrite && !state_q.pready;
        dual = state_q.ctrlTwo[BIT_DUAL];
        wrapEvt = 1'b0;
        rByte = 8'h00;
        hwSet = 8'h00;
        // Pin synchronisers
        state_d.sync1 = {thirdTimerExtClockPin, secondCapturePin, firstCapturePin};
        state_d.sync2 = state_q.sync1;
        state_d.extPrev = state_q.sync2[2];
        // Counter tick source
        if (state_q.ctrlOne[BIT_CLK_SEL]) begin
            tick = state_q.extPrev & ~state_q.sync2[2];
        end else begin
            tick = 1'b1;
        end
        tick = tick & state_q.ctrlTwo[BIT_RUN];
        if (tick) begin
            if (!dual && state_q.count == state_q.period) begin
                state_d.count = CNT_ZERO;
                wrapEvt = 1'b1;
            end else begin
                state_d.count = state_q.count + 16'h0001;
                wrapEvt = dual && (state_q.count == CNT_MAX);
            end
        end
        // Capture channels; first only captures in dual mode
        state_d.ch1 = chanStep(state_q.ch1, state_q.ctrlOne[BIT_ED1_LO +: 2], state_q.sync2[0],
                               state_q.count, rd && dual && idx == IDX_PER_CAP_LO,
                               rd && dual && idx == IDX_PER_CAP_HI, cap1, ovl1, ov1);
        if (!dual) begin
            state_d.ch1 = state_q.ch1;
            state_d.ch1.pinPrev = state_q.sync2[0];
            cap1 = 1'b0;
            ovl1 = 1'b0;
        end
        state_d.ch2 = chanStep(state_q.ch2, state_q.ctrlOne[BIT_ED2_LO +: 2], state_q.sync2[1],
                               state_q.count, rd && idx == IDX_CAP2_LO,
                               rd && idx == IDX_CAP2_HI, cap2, ovl2, ov2);
        if (cap1) begin
            state_d.period = state_d.ch1.value;
        end
        hwSet[BIT_TMR_IRQ] = wrapEvt;
        hwSet[BIT_CAP1_IRQ] = cap1;
        hwSet[BIT_CAP2_IRQ] = cap2;
        // Register writes
        if (wr) begin
            if (idx == IDX_COUNT_LO) begin
                state_d.count[7:0] = wByte;
            end else if (idx == IDX_COUNT_HI) begin
                state_d.count[15:8] = wByte;
            end else if (idx == IDX_PER_CAP_LO) begin
                state_d.period[7:0] = wByte;
            end else if (idx == IDX_PER_CAP_HI) begin
                state_d.period[15:8] = wByte;
            end else if (idx == IDX_FLAGS) begin
                state_d.flags = state_q.flags & ~(wByte & FLAG_HW_MASK); // W1C
            end else if (idx == IDX_ENABLES) begin
                state_d.enables = wByte;
            end else if (idx == IDX_CTRL_ONE) begin
                state_d.ctrlOne = wByte;
            end else if (idx == IDX_CTRL_TWO) begin
                state_d.ctrlTwo[5:0] = wByte[5:0];
            end else if (idx == IDX_CORE_STATUS) begin
                state_d.core[6:0] = wByte[6:0];
            end
        end
        // Hardware set wins over software clear
        state_d.flags = state_d.flags | hwSet;
        if (ovl1) begin
            state_d.ctrlTwo[BIT_OVF1] = ov1;
        end
        if (ovl2) begin
            state_d.ctrlTwo[BIT_OVF2] = ov2;
        end
        state_d.core[BIT_PEIF] = |(state_d.flags & state_d.enables);
        state_d.irq = state_d.core[BIT_PEIF] & state_d.core[BIT_PEIE];
        // Read mux
        if (idx == IDX_CORE_STATUS) begin
            rByte = state_q.core;
        end else if (idx == IDX_COUNT_LO) begin
            rByte = state_q.count[7:0];
        end else if (idx == IDX_COUNT_HI) begin
            rByte = state_q.count[15:8];
        end else if (idx == IDX_CAP2_LO) begin
            rByte = state_q.ch2.value[7:0];
        end else if (idx == IDX_CAP2_HI) begin
            rByte = state_q.ch2.value[15:8];
        end else if (idx == IDX_PER_CAP_LO) begin
            rByte = state_q.period[7:0];
        end else if (idx == IDX_PER_CAP_HI) begin
            rByte = state_q.period[15:8];
        end else if (idx == IDX_FLAGS) begin
            rByte = state_q.flags;
        end else if (idx == IDX_ENABLES) begin
            rByte = state_q.enables;
        end else if (idx == IDX_CTRL_ONE) begin
            rByte = state_q.ctrlOne;
        end else if (idx == IDX_CTRL_TWO) begin
            rByte = state_q.ctrlTwo;
        end
        // One wait state: answer in the cycle after the access phase opens
        state_d.pready = (rd || wr);
        state_d.prdata = rd ? {24'h00_0000, rByte} : 32'h0000_0000;
        state_d.pslverr = 1'b0;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= '0;
            state_q.ctrlOne <= RST_CTRL;
            state_q.ctrlTwo <= RST_CTRL;
            state_q.flags <= RST_FLAGS;
            state_q.enables <= RST_ENABLES;
            state_q.core <= RST_CORE;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from flops
    assign pready = state_q.pready;
    assign prdata = state_q.prdata;
    assign pslverr = state_q.pslverr;
    assign irq = state_q.irq;

endmodule : tdcu_timer3

// ===== tdcu_timer3_checker.sv
`timescale 1ns/10ps
module tdcu_timer3_checker (
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    rst,
    // APB side
    input wire tdcu_pkg::tdcu_apb_req_s apbReq,
    input wire logic                    pready,
    input wire logic [31:0]             prdata,
    input wire logic                    pslverr,
    // Pins and interrupt
    input wire logic                    firstCapturePin,
    input wire logic                    secondCapturePin,
    input wire logic                    thirdTimerExtClockPin,
    input wire logic                    irq
);
    import tdcu_pkg::*;
    // ----------------------------------------------------------------
    // Bus and interrupt properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic       readDone;
    logic [7:0] readIdx;
    // Completed read and the word it addressed
    assign readDone = pready && !apbReq.pwrite;
    assign readIdx  = apbReq.paddr[9:2];
    ready_latency_a: assert property (apbReq.psel && apbReq.penable && !pready |=> pready)
        else $error("answer missing one cycle into the access phase");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(apbReq.psel && apbReq.penable))
        else $error("ready without an access phase");
    no_error_a: assert property ($rose(pready) |-> !pslverr)
        else $error("slave error raised");
    byte_lane_a: assert property (readDone |-> prdata[31:8] == 24'h00_0000)
        else $error("read data above the low byte");
    unmapped_zero_a: assert property (readDone && readIdx > IDX_CTRL_TWO |-> prdata == 32'h0000_0000)
        else $error("unmapped word read not zero");
    flag_fixed_a: assert property (readDone && readIdx == IDX_FLAGS |-> (prdata[7:0] & 8'hB3) == 8'h02)
        else $error("fixed flag bits wrong");
    irq_summary_a: assert property (readDone && readIdx == IDX_CORE_STATUS && prdata[7] && prdata[3]
        |-> ##[0:2] irq)
        else $error("enabled summary without interrupt");
endmodule : tdcu_timer3_checker

bind tdcu_timer3 tdcu_timer3_checker u_tdcu_timer3_checker (.clk(clk), .rst(rst), .apbReq(apbReq),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .firstCapturePin(firstCapturePin),
    .secondCapturePin(secondCapturePin), .thirdTimerExtClockPin(thirdTimerExtClockPin), .irq(irq));

// ===== tdcu_pin_source.sv
`timescale 1ns/10ps
module tdcu_pin_source (
    // Clock
    input  wire logic clk,
    // Pins towards the capture unit
    output logic      firstCapturePin,
    output logic      secondCapturePin,
    output logic      thirdTimerExtClockPin
);
    // ----------------------------------------------------------------
    // Pin levels, idle low so the external clock stands still
    // ----------------------------------------------------------------
    logic [2:0] pinLevel_q = 3'b000;
    assign thirdTimerExtClockPin = pinLevel_q[0];
    assign firstCapturePin       = pinLevel_q[1];
    assign secondCapturePin      = pinLevel_q[2];
    // Whole pulses, each level long enough to pass the synchroniser
    task automatic pulses(input int pin, input int count);
        repeat (count) begin
            @(posedge clk);
            pinLevel_q[pin] <= 1'b1;
            repeat (4) @(posedge clk);
            pinLevel_q[pin] <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : pulses
endmodule : tdcu_pin_source

// ===== test_timer3_dual_capture_unit.sv
`timescale 1ns/10ps
module test_timer3_dual_capture_unit;
    import tdcu_pkg::*;
    // ----------------------------------------------------------------
    // Signals and register table
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic [7:0] idx;
        logic [7:0] data;
    } tdcu_row_s;
    logic          clk;
    logic          rst;
    tdcu_apb_req_s apbReq;
    logic          pready;
    logic [31:0]   prdata;
    logic          pslverr;
    logic          firstCapturePin;
    logic          secondCapturePin;
    logic          thirdTimerExtClockPin;
    logic          irq;
    logic [7:0]    rdByte;
    logic [15:0]   word;
    logic [15:0]   word2;
    int            miscompares;
    int            samples_checked;
    // Reads carry the expected byte, writes the byte to store
    tdcu_row_s     rows [17] = '{'{1'b0, 8'h07, 8'h00}, '{1'b0, 8'h20, 8'h02}, '{1'b0, 8'h21, 8'h00},
        '{1'b0, 8'h22, 8'h00}, '{1'b0, 8'h23, 8'h00}, '{1'b1, 8'h20, 8'hFF}, '{1'b0, 8'h20, 8'h02},
        '{1'b1, 8'h21, 8'h4C}, '{1'b0, 8'h21, 8'h4C}, '{1'b1, 8'h22, 8'hF0}, '{1'b0, 8'h22, 8'hF0},
        '{1'b1, 8'h12, 8'h34}, '{1'b1, 8'h13, 8'h12}, '{1'b0, 8'h12, 8'h34}, '{1'b0, 8'h13, 8'h12},
        '{1'b1, 8'h30, 8'hAA}, '{1'b0, 8'h30, 8'h00}};

    tdcu_timer3 u_tdcu_timer3 (.clk(clk), .rst(rst), .apbReq(apbReq), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .firstCapturePin(firstCapturePin), .secondCapturePin(secondCapturePin),
        .thirdTimerExtClockPin(thirdTimerExtClockPin), .irq(irq));
    tdcu_pin_source u_tdcu_pin_source (.clk(clk), .firstCapturePin(firstCapturePin),
        .secondCapturePin(secondCapturePin), .thirdTimerExtClockPin(thirdTimerExtClockPin));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // Verdict and end of run
    task final_report;
        if (miscompares == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    // One APB transfer, held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] data);
        int waits;
        @(posedge clk);
        apbReq.psel    <= 1'b1;
        apbReq.pwrite  <= wr;
        apbReq.paddr   <= {22'h00_0000, idx, 2'b00};
        apbReq.pwdata  <= {24'h00_0000, data};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        waits = 0;
        do begin
            @(posedge clk);
            waits++;
        end while (pready !== 1'b1 && waits < 20);
        rdByte = prdata[7:0];
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            final_report();
        end
    endtask : apb
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic expectReg(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check($sformatf("register %h", idx), {8'h00, exp}, {8'h00, rdByte & mask});
    endtask : expectReg
    task automatic readWord(input logic [7:0] idx, output logic [15:0] w);
        apb(1'b0, idx, 8'h00);
        w[7:0] = rdByte;
        apb(1'b0, 8'(idx + 8'h01), 8'h00);
        w[15:8] = rdByte;
    endtask : readWord
    task automatic setCount(input logic [15:0] v);
        apb(1'b1, IDX_COUNT_LO, v[7:0]);
        apb(1'b1, IDX_COUNT_HI, v[15:8]);
    endtask : setCount

    // ----------------------------------------------------------------
    // Clock and main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        apbReq = '0;
        miscompares = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) apb(1'b1, rows[i].idx, rows[i].data);
            else expectReg(rows[i].idx, 8'hFF, rows[i].data);
        end
        // Period mode restarts from zero on reaching the period value
        apb(1'b1, IDX_PER_CAP_LO, 8'h05);
        apb(1'b1, IDX_PER_CAP_HI, 8'h00);
        setCount(16'h0000);
        apb(1'b1, IDX_CTRL_TWO, 8'h04);
        repeat (30) @(posedge clk);
        apb(1'b1, IDX_CTRL_TWO, 8'h00);
        expectReg(IDX_FLAGS, 8'h40, 8'h40);
        readWord(IDX_COUNT_LO, word);
        check("period count", 16'h0001, {15'h0000, word <= 16'h0005});
        apb(1'b1, IDX_FLAGS, 8'h40);
        repeat (10) @(posedge clk);
        expectReg(IDX_FLAGS, 8'h40, 8'h00);
        readWord(IDX_COUNT_LO, word2);
        check("stopped count", word, word2);
        // Dual mode runs through FFFFh
        setCount(16'hFFF8);
        apb(1'b1, IDX_CTRL_TWO, 8'h0C);
        repeat (12) @(posedge clk);
        apb(1'b1, IDX_CTRL_TWO, 8'h08);
        expectReg(IDX_FLAGS, 8'h40, 8'h40);
        readWord(IDX_COUNT_LO, word);
        check("wrapped count", 16'h0001, {15'h0000, word < 16'h0040});
        // Captures on both pins, then a second event before the read
        apb(1'b1, IDX_FLAGS, 8'h4C);
        apb(1'b1, IDX_CTRL_ONE, 8'h10);
        setCount(16'hABCD);
        for (int k = 0; k < 2; k++) begin
            u_tdcu_pin_source.pulses(2, 1);
            u_tdcu_pin_source.pulses(1, 1);
            repeat (6) @(posedge clk);
            setCount(16'h1111);
        end
        expectReg(IDX_FLAGS, 8'h0C, 8'h0C);
        readWord(IDX_CAP2_LO, word);
        check("second capture", 16'hABCD, word);
        expectReg(IDX_CTRL_TWO, 8'h80, 8'h80);
        readWord(IDX_PER_CAP_LO, word);
        check("first capture", 16'hABCD, word);
        expectReg(IDX_CTRL_TWO, 8'hC0, 8'hC0);
        // Every 4th and every 16th rising edge
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, IDX_FLAGS, 8'h08);
            apb(1'b1, IDX_CTRL_ONE, m ? 8'hC0 : 8'h80);
            setCount(m ? 16'h2223 : 16'h2222);
            u_tdcu_pin_source.pulses(2, m ? 16 : 4);
            repeat (6) @(posedge clk);
            expectReg(IDX_FLAGS, 8'h08, 8'h08);
            readWord(IDX_CAP2_LO, word);
            check("prescaled capture", m ? 16'h2223 : 16'h2222, word);
        end
        // Interrupt raised, masked and cleared
        apb(1'b1, IDX_ENABLES, 8'h08);
        apb(1'b1, IDX_CORE_STATUS, 8'h08);
        expectReg(IDX_CORE_STATUS, 8'h88, 8'h88);
        check("irq raised", 16'h0001, {15'h0000, irq});
        apb(1'b1, IDX_ENABLES, 8'h00);
        repeat (2) @(posedge clk);
        check("irq masked", 16'h0000, {15'h0000, irq});
        apb(1'b1, IDX_ENABLES, 8'h08);
        apb(1'b1, IDX_FLAGS, 8'h08);
        repeat (2) @(posedge clk);
        check("irq cleared", 16'h0000, {15'h0000, irq});
        // External clock counts its falling edges only
        apb(1'b1, IDX_CTRL_ONE, 8'h04);
        setCount(16'h0000);
        apb(1'b1, IDX_CTRL_TWO, 8'h0C);
        u_tdcu_pin_source.pulses(0, 3);
        repeat (6) @(posedge clk);
        apb(1'b1, IDX_CTRL_TWO, 8'h08);
        readWord(IDX_COUNT_LO, word);
        check("external count", 16'h0003, word);
        // Reset in mid-run returns the control words to their reset values
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        expectReg(IDX_CTRL_ONE, 8'hFF, RST_CTRL);
        expectReg(IDX_CTRL_TWO, 8'hFF, RST_CTRL);
        expectReg(IDX_FLAGS, 8'hFF, RST_FLAGS);
        check("irq after reset", 16'h0000, {15'h0000, irq});
        final_report();
    end
endmodule : test_timer3_dual_capture_unit
